/* File: src/cte_defines.svh */
// Purpose: register offsets, field positions, reset values and source codes
//          of the charge time unit edge logic
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef CTE_DEFINES_SVH
`define CTE_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CTE_ADDR_EDGE_CTRL 12'h000
`define CTE_ADDR_UNIT_CTRL 12'h004
`define CTE_ADDR_IRQ_STAT 12'h008
`define CTE_ADDR_IRQ_MASK 12'h00c
`define CTE_ADDR_LIVE 12'h010

// ----------------------------------------------------------------------------
// edge_source_control field positions; CTE_UNIT_EN is the enable bit of the unit control word
// ----------------------------------------------------------------------------
`define CTE_F1_SENS 15
`define CTE_F1_POL 14
`define CTE_F1_SEL_HI 13
`define CTE_F1_SEL_LO 10
`define CTE_F2_SEEN 9
`define CTE_F1_SEEN 8
`define CTE_F2_SENS 7
`define CTE_F2_POL 6
`define CTE_F2_SEL_HI 5
`define CTE_F2_SEL_LO 2
`define CTE_UNIT_EN 0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CTE_RST_EDGE_CTRL 16'h0000
`define CTE_RST_UNIT_CTRL 1'h0
`define CTE_RST_IRQ 3'h0

// ----------------------------------------------------------------------------
// edge source select codes
// ----------------------------------------------------------------------------
`define CTE_SRC_TIMER 4'h0
`define CTE_SRC_OC1 4'h1
`define CTE_SRC_EXT1 4'h2
`define CTE_SRC_EXT7 4'h8
`define CTE_SRC_EXT8 4'h9
`define CTE_SRC_IC1 4'ha
`define CTE_SRC_IC2 4'hb
`define CTE_SRC_IC3 4'hc
`define CTE_SRC_CMP1 4'hd
`define CTE_SRC_CMP2 4'he
`define CTE_SRC_CMP3 4'hf

`endif

/* File: src/cte_pkg.sv */
// Purpose: shared types of the charge time unit edge logic
// Assumes: nothing beyond the defines header
// Notes:   all module state lives in the structs declared here
package cte_pkg;

  // --------------------------------------------------------------------------
  // trigger sources
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cmp;      // comparator 3..1 outputs
    logic [2:0] capture;  // input capture 3..1
    logic [12:0] ext;     // external edge pins 13..1
    logic oc1;            // output compare one
    logic timer;          // general timer one
  } cte_src_s;

  // --------------------------------------------------------------------------
  // module states
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic prev;
  } cte_qual_s;

  typedef struct packed {
    logic [15:0] edge_ctrl;
    logic enable;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic pulse;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cte_state_s;

endpackage

/* File: src/cte_src_select.sv */
// Purpose: picks one trigger source level from a 4-bit select code
// Assumes: sources are synchronous to the unit clock
// Notes:   pin 7 is dropped when the small package is built
`timescale 1ns/1ps
`include "cte_defines.svh"
module cte_src_select #(
  parameter bit SMALL_PKG = 1'b0
) (
  // select and sources
  input wire logic [3:0] sel,
  input wire cte_pkg::cte_src_s src,
  // chosen level
  output logic level
);

  logic [2:0] ext_idx;

  // pin codes 2..9 map onto pins 1..8
  assign ext_idx = 3'(sel - `CTE_SRC_EXT1);

  // ---------------------------------------------------------------------------
  // source multiplexer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    unique case (sel)
      `CTE_SRC_CMP3: level = src.cmp[2];
      `CTE_SRC_CMP2: level = src.cmp[1];
      `CTE_SRC_CMP1: level = src.cmp[0];
      `CTE_SRC_IC3: level = src.capture[2];
      `CTE_SRC_IC2: level = src.capture[1];
      `CTE_SRC_IC1: level = src.capture[0];
      `CTE_SRC_OC1: level = src.oc1;
      `CTE_SRC_TIMER: level = src.timer;
      // missing pin in the small package gives a quiet source
      `CTE_SRC_EXT7: level = SMALL_PKG ? 1'b0 : src.ext[6];
      default: level = src.ext[ext_idx];
    endcase
  end

endmodule

/* File: src/cte_edge_qual.sv */
// Purpose: qualifies one source by polarity and level or edge sensitivity
// Assumes: source level synchronous to clk
// Notes:   previous level tracks even while the unit is off, so enabling
//          never sees a stale edge
`timescale 1ns/1ps
module cte_edge_qual (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic level,
  input wire logic polarity,
  input wire logic edge_mode,
  // qualified event, combinational
  output logic hit
);

  cte_pkg::cte_qual_s st;
  cte_pkg::cte_qual_s next_st;

  // ---------------------------------------------------------------------------
  // event decision
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_st.prev = level;
    if (edge_mode)
      hit = (level == polarity) && (st.prev != polarity);
    else
      hit = (level == polarity);
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

endmodule

/* File: src/cte_edge_unit.sv */
// Purpose: edge sequencing of the charge time unit: two qualified edge
//          channels, sticky seen flags, pulse and current source enable
// Assumes: 200 MHz clk, APB slave with zero wait states
// Notes:   all outputs are registered; events only count while enabled
//
// Operation
// - each channel responds to the level or to transitions of its source per its sensitivity bit.
// - first polarity 1 means rising edge response, 0 means falling.
// - second polarity 1 means rising edge response, 0 means falling.
// - first select codes 1111, 1110, 1101 pick comparator 3, 2, 1.
// - first select codes 1100, 1011, 1010 pick input capture 3, 2, 1.
// - first select code 1001 picks pin 8, lower codes down to 0010 pick pins 7 to 1.
// - up to thirteen external edge pins plus timer and compare are accepted; the code takes thirteen pins but its select codes reach pins 1 to 8 only.
// - pin 7 is absent in the small package and then gives no events; the code reads it as 0, so level mode with polarity 0 fires every cycle.
// - second seen flag reads 1 after a qualified second event; software may write it.
// - first seen flag reads 1 after a qualified first event; software may write it.
// - output pulse spans the time between the two qualified events.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "cte_defines.svh"
module cte_edge_unit #(
  parameter bit SMALL_PKG = 1'b0,
  parameter int AW = 12
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger sources
  input wire cte_pkg::cte_src_s src,
  // unit outputs
  output logic pulse_out,
  output logic current_enable,
  output logic irq
);

  cte_pkg::cte_state_s st;
  cte_pkg::cte_state_s next_st;
  logic lvl1;
  logic lvl2;
  logic hit1;
  logic hit2;
  logic ev1;
  logic ev2;
  logic access;
  logic wr;
  logic [11:0] addr;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [31:0] rd_word;
  logic rd_ok;

  // ---------------------------------------------------------------------------
  // source selection and qualification, one instance per channel
  // ---------------------------------------------------------------------------
  cte_src_select #(.SMALL_PKG(SMALL_PKG)) u_sel1 (
    .sel(st.edge_ctrl[`CTE_F1_SEL_HI:`CTE_F1_SEL_LO]),
    .src(src),
    .level(lvl1)
  );

  // same table serves the second channel
  cte_src_select #(.SMALL_PKG(SMALL_PKG)) u_sel2 (
    .sel(st.edge_ctrl[`CTE_F2_SEL_HI:`CTE_F2_SEL_LO]),
    .src(src),
    .level(lvl2)
  );

  cte_edge_qual u_qual1 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .level(lvl1),
    .polarity(st.edge_ctrl[`CTE_F1_POL]),
    .edge_mode(st.edge_ctrl[`CTE_F1_SENS]),
    .hit(hit1)
  );

  cte_edge_qual u_qual2 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .level(lvl2),
    .polarity(st.edge_ctrl[`CTE_F2_POL]),
    .edge_mode(st.edge_ctrl[`CTE_F2_SENS]),
    .hit(hit2)
  );

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  // pready is already high in the first access cycle, so every access ends there
  assign access = psel && penable && st.pready;
  assign wr = access && pwrite;
  assign addr = 12'(paddr);
  assign ev1 = st.enable && hit1;
  assign ev2 = st.enable && hit2;

  // read mux, evaluated in the setup cycle
  always_comb
  begin
    rd_word = '0;
    rd_ok = 1'b1;
    unique case (addr)
      `CTE_ADDR_EDGE_CTRL: rd_word = {16'h0000, st.edge_ctrl[15:2], 2'h0};
      `CTE_ADDR_UNIT_CTRL: rd_word = {31'h0, st.enable};
      `CTE_ADDR_IRQ_STAT: rd_word = {29'h0, st.irq_stat};
      `CTE_ADDR_IRQ_MASK: rd_word = {29'h0, st.irq_mask};
      `CTE_ADDR_LIVE: rd_word = {29'h0, st.pulse, st.edge_ctrl[`CTE_F2_SEEN],
        st.edge_ctrl[`CTE_F1_SEEN]};
      default: rd_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    irq_clr = 3'h0;
    // software write to the control word; low two bits are not stored
    if (wr && addr == `CTE_ADDR_EDGE_CTRL)
      next_st.edge_ctrl = {pwdata[15:2], 2'h0};
    if (wr && addr == `CTE_ADDR_UNIT_CTRL)
      next_st.enable = pwdata[`CTE_UNIT_EN];
    if (wr && addr == `CTE_ADDR_IRQ_MASK)
      next_st.irq_mask = pwdata[2:0];
    if (wr && addr == `CTE_ADDR_IRQ_STAT)
      irq_clr = pwdata[2:0];
    // a hardware event beats a software clear in the same cycle
    if (ev1)
      next_st.edge_ctrl[`CTE_F1_SEEN] = 1'b1;
    if (ev2)
      next_st.edge_ctrl[`CTE_F2_SEEN] = 1'b1;
    // pulse runs from first event to second event
    next_st.pulse = next_st.edge_ctrl[`CTE_F1_SEEN]
      && !next_st.edge_ctrl[`CTE_F2_SEEN];
    irq_set = {st.pulse && !next_st.pulse, ev2, ev1};
    next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    // answer prepared in the setup cycle, shown during the access cycle
    if (psel && !penable)
    begin
      next_st.pready = 1'b1;
      next_st.pslverr = !rd_ok;
      next_st.prdata = pwrite ? 32'h0 : rd_word;
    end
    else
    begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0;
    end
  end

  // single state register, frozen while ce is low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.edge_ctrl <= `CTE_RST_EDGE_CTRL;
      st.enable <= `CTE_RST_UNIT_CTRL;
      st.irq_stat <= `CTE_RST_IRQ;
      st.irq_mask <= `CTE_RST_IRQ;
    end
    else if (ce)
      st <= next_st;
  end

  // outputs straight from the state flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pulse_out = st.pulse;
  assign current_enable = st.pulse;
  assign irq = st.irq;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  first_seen_set_a: assert property (ce && ev1 |=> st.edge_ctrl[`CTE_F1_SEEN])
    else $error("first seen flag not set after qualified event");

  second_seen_set_a: assert property (ce && ev2 |=> st.edge_ctrl[`CTE_F2_SEEN])
    else $error("second seen flag not set after qualified event");

  seen_hold_a: assert property (
    ce && st.edge_ctrl[`CTE_F1_SEEN] && !wr |=> st.edge_ctrl[`CTE_F1_SEEN])
    else $error("first seen flag dropped without software");

  cur_enable_a: assert property (
    current_enable == (st.edge_ctrl[`CTE_F1_SEEN] && !st.edge_ctrl[`CTE_F2_SEEN]))
    else $error("current enable does not follow seen flags");

  pulse_end_a: assert property (ce && pulse_out && ev2 |=> !pulse_out)
    else $error("pulse did not end on second event");

  edge_mode_a: assert property (
    ce && $past(ce) && st.edge_ctrl[`CTE_F1_SENS]
    && lvl1 == st.edge_ctrl[`CTE_F1_POL] && $past(lvl1) == st.edge_ctrl[`CTE_F1_POL]
    |-> !hit1)
    else $error("edge mode fired on steady level");

  rise_pol_a: assert property (
    ce && $past(ce) && st.edge_ctrl[`CTE_F1_SENS]
    && st.edge_ctrl[`CTE_F1_POL] && lvl1 && !$past(lvl1) |-> hit1)
    else $error("rising edge missed on first channel");

  fall_pol_a: assert property (
    ce && $past(ce) && st.edge_ctrl[`CTE_F2_SENS]
    && !st.edge_ctrl[`CTE_F2_POL] && !lvl2 && $past(lvl2) |-> hit2)
    else $error("falling edge missed on second channel");

  cmp_pick_a: assert property (
    st.edge_ctrl[`CTE_F1_SEL_HI:`CTE_F1_SEL_LO] == `CTE_SRC_CMP3 |-> lvl1 == src.cmp[2])
    else $error("code 1111 did not pick comparator 3");

  cap_pick_a: assert property (
    st.edge_ctrl[`CTE_F1_SEL_HI:`CTE_F1_SEL_LO] == `CTE_SRC_IC1 |-> lvl1 == src.capture[0])
    else $error("code 1010 did not pick capture 1");

  timer_pick_a: assert property (
    st.edge_ctrl[`CTE_F1_SEL_HI:`CTE_F1_SEL_LO] == `CTE_SRC_TIMER |-> lvl1 == src.timer)
    else $error("code 0000 did not pick the timer");

  pin_pick_a: assert property (
    st.edge_ctrl[`CTE_F1_SEL_HI:`CTE_F1_SEL_LO] == `CTE_SRC_EXT8 |-> lvl1 == src.ext[7])
    else $error("code 1001 did not pick pin 8");

  small_pkg_a: assert property (
    SMALL_PKG && st.edge_ctrl[`CTE_F1_SEL_HI:`CTE_F1_SEL_LO] == `CTE_SRC_EXT7 |-> !lvl1)
    else $error("absent pin 7 produced a level");

  second_map_a: assert property (
    st.edge_ctrl[`CTE_F2_SEL_HI:`CTE_F2_SEL_LO] == `CTE_SRC_CMP1 |-> lvl2 == src.cmp[0])
    else $error("second selector encoding differs");

  low_bits_a: assert property (
    access && !pwrite && addr == `CTE_ADDR_EDGE_CTRL |-> prdata[1:0] == 2'h0)
    else $error("unimplemented bits read nonzero");

  irq_level_a: assert property (irq == |(st.irq_stat & st.irq_mask))
    else $error("interrupt output disagrees with masked status");

  second_hold_a: assert property (
    ce && st.edge_ctrl[`CTE_F2_SEEN] && !wr |=> st.edge_ctrl[`CTE_F2_SEEN])
    else $error("second seen flag dropped without software");

  // level mode fires on every cycle the source sits at the chosen level
  level_mode_a: assert property (
    !st.edge_ctrl[`CTE_F1_SENS] && lvl1 == st.edge_ctrl[`CTE_F1_POL] |-> hit1)
    else $error("level mode missed a level on first channel");

  second_level_a: assert property (
    !st.edge_ctrl[`CTE_F2_SENS] && lvl2 == st.edge_ctrl[`CTE_F2_POL] |-> hit2)
    else $error("level mode missed a level on second channel");

  // with the unit off only software may touch the control word
  off_quiet_a: assert property (ce && !st.enable && !wr |=> $stable(st.edge_ctrl))
    else $error("control word moved while the unit was off");

  event_irq_a: assert property (ce && ev2 |=> st.irq_stat[1])
    else $error("second event did not raise its status bit");

  // ---------------------------------------------------------------------------
  // bus and clock enable
  // ---------------------------------------------------------------------------
  // zero wait states: the answer is due in the cycle after setup
  apb_ready_a: assert property (ce && psel && !penable |=> pready)
    else $error("ready did not follow the setup cycle");

  ready_drop_a: assert property (ce && pready && penable |=> !pready)
    else $error("ready stood longer than one access cycle");

  bad_addr_a: assert property (ce && psel && !penable && !rd_ok |=>
    pslverr && prdata == 32'h0)
    else $error("unmapped address was not refused");

  // a frozen unit must neither lose nor invent state while ce is low
  ce_freeze_a: assert property (!ce |=> $stable(st))
    else $error("state moved while clock enable was low");

  pulse_seen_c: cover property (!pulse_out ##1 pulse_out ##[1:20] !pulse_out);
  both_seen_c: cover property (st.edge_ctrl[`CTE_F1_SEEN] && st.edge_ctrl[`CTE_F2_SEEN]);
  irq_raise_c: cover property (!irq ##1 irq);
  sw_clear_c: cover property (wr && addr == `CTE_ADDR_IRQ_STAT && irq);
  ce_freeze_c: cover property (!ce ##1 ce);

endmodule

/* File: verif/cte_src_model.sv */
// Purpose: model of the peripherals and pins that feed the edge unit
// Assumes: all sources are levels synchronous to clk
// Notes:   every source is always driven, so no released state exists
`timescale 1ns/1ps
module cte_src_model (
  // clock
  input wire logic clk,
  // source levels
  output cte_pkg::cte_src_s src
);
  // ------
  // drive
  // ------
  initial src = '0;

  // levels move just after an edge, as a clocked peripheral would
  task automatic drive(input logic [20:0] v);
    @(posedge clk);
    src <= v;
  endtask
endmodule

/* File: verif/tb_cte_edge_unit.sv */
// Purpose: self-checking bench of the edge unit
// Assumes: zero wait state apb slave, registered outputs
// Notes:   ce drops once in t_hold; the small package option is not built
`timescale 1ns/1ps
`include "cte_defines.svh"
module tb_cte_edge_unit;
  localparam int GAP = 7;
  logic clk, rst, ce, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, pulse_out, current_enable, irq, e;
  cte_pkg::cte_src_s src;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int pw = 0;

  // ------
  // design and sources
  // ------
  cte_edge_unit u_cte_edge_unit (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
    .pulse_out(pulse_out), .current_enable(current_enable), .irq(irq));
  cte_src_model u_cte_src_model (.clk(clk), .src(src));

  // ------
  // helpers
  // ------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulse width counted at the falling edge, where it is settled
  always @(negedge clk)
    if (pulse_out === 1'b1)
      pw <= pw + 1;

  // a hang ends the run as a failure
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      final_report;
    end
  end

  task automatic final_report;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    // a slave that never answers counts as a failure
    if (pready !== 1'b1)
      errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_reset;
    chk({29'h0, pulse_out, current_enable, irq}, 32'h0);
    apb(1'b0, `CTE_ADDR_EDGE_CTRL, 32'h0);
    chk(q, {16'h0, `CTE_RST_EDGE_CTRL});
    apb(1'b0, `CTE_ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
  endtask

  // software drives the seen bits straight to the current source
  task automatic t_regs;
    apb(1'b1, `CTE_ADDR_EDGE_CTRL, 32'hffffffff);
    apb(1'b0, `CTE_ADDR_EDGE_CTRL, 32'h0);
    chk(q, 32'h0000fffc);
    apb(1'b1, `CTE_ADDR_EDGE_CTRL, 32'h00000100);
    tick(3);
    chk({31'h0, current_enable}, 32'h1);
    apb(1'b1, `CTE_ADDR_EDGE_CTRL, 32'h00000300);
    tick(3);
    chk({31'h0, current_enable}, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask

  // every select code of both channels, level mode, positive
  task automatic t_select;
    logic [20:0] m;
    logic [31:0] c;
    apb(1'b1, `CTE_ADDR_UNIT_CTRL, 32'h1);
    for (int ch = 0; ch < 2; ch++)
      for (int k = 0; k < 16; k++)
      begin
        m = 21'h1 << (k < 10 ? k : k + 5);
        c = (ch == 1) ? ((32'(k) << 2) | 32'h40) : ((32'(k) << 10) | 32'h4000);
        u_cte_src_model.drive(~m);
        apb(1'b1, `CTE_ADDR_EDGE_CTRL, c);
        // old selection may fire at the first write and a set beats the clear
        apb(1'b1, `CTE_ADDR_EDGE_CTRL, c);
        tick(3);
        apb(1'b0, `CTE_ADDR_LIVE, 32'h0);
        chk({31'h0, q[ch]}, 32'h0);
        u_cte_src_model.drive(m);
        tick(3);
        apb(1'b0, `CTE_ADDR_LIVE, 32'h0);
        chk({31'h0, q[ch]}, 32'h1);
      end
  endtask

  // first: timer rising edge; second: compare falling edge
  task automatic t_edge;
    int p0;
    u_cte_src_model.drive(21'h3);
    apb(1'b1, `CTE_ADDR_EDGE_CTRL, 32'h0000c084);
    apb(1'b1, `CTE_ADDR_IRQ_STAT, 32'h7);
    tick(3);
    apb(1'b0, `CTE_ADDR_LIVE, 32'h0);
    chk(q, 32'h0);
    u_cte_src_model.drive(21'h2);
    tick(3);
    apb(1'b0, `CTE_ADDR_LIVE, 32'h0);
    chk(q, 32'h0);
    p0 = pw;
    u_cte_src_model.drive(21'h3);
    repeat (GAP) @(posedge clk);
    u_cte_src_model.drive(21'h1);
    tick(4);
    chk(32'(pw - p0), 32'(GAP + 1));
    apb(1'b0, `CTE_ADDR_LIVE, 32'h0);
    chk(q, 32'h3);
    apb(1'b0, `CTE_ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h7);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `CTE_ADDR_IRQ_MASK, 32'h4);
    tick(3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `CTE_ADDR_IRQ_STAT, 32'h4);
    tick(3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `CTE_ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h3);
  endtask

  // clock enable low holds every flop; the missed edge is seen once it rises
  task automatic t_hold;
    apb(1'b1, `CTE_ADDR_EDGE_CTRL, 32'h0000c084);
    u_cte_src_model.drive(21'h2);
    tick(2);
    @(posedge clk);
    ce <= 1'b0;
    u_cte_src_model.drive(21'h3);
    tick(4);
    chk({31'h0, current_enable}, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    tick(3);
    chk({31'h0, current_enable}, 32'h1);
  endtask

  // ------
  // main sequence
  // ------
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_select;
    t_edge;
    t_hold;
    final_report;
  end
endmodule
